/* File: dpbr_pkg.sv */
// dual port block ram: shared constants and types
`default_nettype none
package dpbr_pkg;
    // documented-free defaults; the array is sized by the module parameters
    localparam int unsigned ADDR_W_DEF = 9;
    localparam int unsigned DATA_W_DEF = 18;
    localparam int unsigned NUM_PORTS  = 2;
    // port indices into the internal per-port arrays
    localparam int unsigned PORT_A = 0;
    localparam int unsigned PORT_B = 1;
    // value the output latches take when cleared
    localparam logic DOUT_CLEAR_BIT = 1'b0;
    // write behaviour of one port
    typedef enum logic {
        DPBR_WR_NORMAL,
        DPBR_WR_THROUGH
    } dpbr_wr_mode_t;
endpackage : dpbr_pkg
`default_nettype wire

/* File: dpbr_block_ram.sv */
// dual port block ram: array, input registers, output latches and resets
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (RL1) each port registers write data and address before the array uses them
// (RL2) optional output register per port; when off, latch output goes straight out
// (RL3) normal write mode: output changes on reads only, never shows written word
// (RL4) write-through mode: output shows the word being written, same cycle
// (RL5) output latches are reset sync or async, chosen by configuration
// (RL6) each port's local reset clears only that port's outputs
// (RL7) active-low global reset clears outputs of both ports
// (RL8) ports independent; read data one clock after registered address, two with output register
module dpbr_block_ram #(
    parameter int unsigned           ADDR_W        = dpbr_pkg::ADDR_W_DEF,
    parameter int unsigned           DATA_W        = dpbr_pkg::DATA_W_DEF,
    parameter dpbr_pkg::dpbr_wr_mode_t WR_MODE_A   = dpbr_pkg::DPBR_WR_NORMAL,
    parameter dpbr_pkg::dpbr_wr_mode_t WR_MODE_B   = dpbr_pkg::DPBR_WR_NORMAL,
    parameter bit                    OUT_REG_A     = 1'b0,
    parameter bit                    OUT_REG_B     = 1'b0,
    parameter bit                    OUT_RST_ASYNC = 1'b0
) (
    // clock, reset and freeze
    input  wire logic              clk_sys_in,
    input  wire logic              arst_n_in,
    input  wire logic              clk_en_in,
    input  wire logic              global_reset_low_in,
    // port a
    input  wire logic              a_en_in,
    input  wire logic              a_we_in,
    input  wire logic [ADDR_W-1:0] a_addr_in,
    input  wire logic [DATA_W-1:0] a_wdata_in,
    input  wire logic              port_a_output_reset_in,
    output logic      [DATA_W-1:0] a_rdata_out,
    // port b
    input  wire logic              b_en_in,
    input  wire logic              b_we_in,
    input  wire logic [ADDR_W-1:0] b_addr_in,
    input  wire logic [DATA_W-1:0] b_wdata_in,
    input  wire logic              port_b_output_reset_in,
    output logic      [DATA_W-1:0] b_rdata_out
);

    //------------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------------
    // deepest array one block serves; wider addresses need cascading
    localparam int unsigned ADDR_W_MAX = 16;

    if (ADDR_W < 1 || ADDR_W > ADDR_W_MAX) begin : g_bad_addr
        $error("dpbr_block_ram: ADDR_W must be 1..16");
    end
    if (DATA_W < 1) begin : g_bad_data
        $error("dpbr_block_ram: DATA_W must be at least 1");
    end

    localparam int unsigned NP    = dpbr_pkg::NUM_PORTS;
    localparam int unsigned DEPTH = 1 << ADDR_W;
    localparam logic [DATA_W-1:0] DOUT_CLEAR = {DATA_W{dpbr_pkg::DOUT_CLEAR_BIT}};

    //------------------------------------------------------------------
    // per-port views of the separate ports
    //------------------------------------------------------------------
    logic              en_in_w    [NP];
    logic              we_in_w    [NP];
    logic [ADDR_W-1:0] addr_in_w  [NP];
    logic [DATA_W-1:0] wdata_in_w [NP];
    logic              lrst_w     [NP];
    logic              wthru_w    [NP];
    logic [DATA_W-1:0] rdata_w    [NP];

    // gather ports so both ends share one description
    assign en_in_w[dpbr_pkg::PORT_A]    = a_en_in;
    assign en_in_w[dpbr_pkg::PORT_B]    = b_en_in;
    assign we_in_w[dpbr_pkg::PORT_A]    = a_we_in;
    assign we_in_w[dpbr_pkg::PORT_B]    = b_we_in;
    assign addr_in_w[dpbr_pkg::PORT_A]  = a_addr_in;
    assign addr_in_w[dpbr_pkg::PORT_B]  = b_addr_in;
    assign wdata_in_w[dpbr_pkg::PORT_A] = a_wdata_in;
    assign wdata_in_w[dpbr_pkg::PORT_B] = b_wdata_in;
    // a local reset only touches its own port; global low hits both
    assign lrst_w[dpbr_pkg::PORT_A]     = port_a_output_reset_in | ~global_reset_low_in; // [RL6] [RL7]
    assign lrst_w[dpbr_pkg::PORT_B]     = port_b_output_reset_in | ~global_reset_low_in; // [RL6] [RL7]
    assign wthru_w[dpbr_pkg::PORT_A]    = (WR_MODE_A == dpbr_pkg::DPBR_WR_THROUGH);
    assign wthru_w[dpbr_pkg::PORT_B]    = (WR_MODE_B == dpbr_pkg::DPBR_WR_THROUGH);
    assign a_rdata_out                  = rdata_w[dpbr_pkg::PORT_A];
    assign b_rdata_out                  = rdata_w[dpbr_pkg::PORT_B];

    //------------------------------------------------------------------
    // input registers of both ports
    //------------------------------------------------------------------
    logic              en_reg    [NP];
    logic              we_reg    [NP];
    logic [ADDR_W-1:0] addr_reg  [NP];
    logic [DATA_W-1:0] wdata_reg [NP];
    logic              en_next    [NP];
    logic              we_next    [NP];
    logic [ADDR_W-1:0] addr_next  [NP];
    logic [DATA_W-1:0] wdata_next [NP];

    // capture request; the array only ever sees the registered copy
    always_comb begin
        for (int p = 0; p < NP; p++) begin
            en_next[p]    = en_reg[p];
            we_next[p]    = we_reg[p];
            addr_next[p]  = addr_reg[p];
            wdata_next[p] = wdata_reg[p];
            if (clk_en_in) begin
                en_next[p]    = en_in_w[p];              // [RL1]
                we_next[p]    = en_in_w[p] & we_in_w[p]; // [RL1]
                addr_next[p]  = addr_in_w[p];            // [RL1]
                wdata_next[p] = wdata_in_w[p];           // [RL1]
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            for (int p = 0; p < NP; p++) begin
                en_reg[p]    <= 1'b0;
                we_reg[p]    <= 1'b0;
                addr_reg[p]  <= '0;
                wdata_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                en_reg[p]    <= en_next[p];
                we_reg[p]    <= we_next[p];
                addr_reg[p]  <= addr_next[p];
                wdata_reg[p] <= wdata_next[p];
            end
        end
    end

    //------------------------------------------------------------------
    // memory array
    //------------------------------------------------------------------
    logic [DATA_W-1:0] mem [DEPTH];

    // array has no reset so it maps onto ram cells; port b written last,
    // so it wins when both ports write one address in the same cycle;
    // a read of an address the other port writes in the same cycle
    // returns the old word, since the latch loads before the write lands
    always_ff @(posedge clk_sys_in) begin
        if (clk_en_in) begin
            for (int p = 0; p < NP; p++) begin
                if (en_reg[p] && we_reg[p]) begin
                    mem[addr_reg[p]] <= wdata_reg[p]; // [RL8]
                end
            end
        end
    end

    //------------------------------------------------------------------
    // output latches, optional output register, resets
    //------------------------------------------------------------------
    for (genvar gp = 0; gp < NP; gp++) begin : g_port
        logic [DATA_W-1:0] dout_reg;
        logic [DATA_W-1:0] dout_next;
        logic [DATA_W-1:0] pipe_reg;
        logic [DATA_W-1:0] pipe_next;

        // output register choice of this port, fixed at elaboration
        localparam bit USE_PIPE = (gp == dpbr_pkg::PORT_A) ? OUT_REG_A : OUT_REG_B;

        // latch update; a sync clear is folded in here, an async one is not
        always_comb begin
            dout_next = dout_reg;
            pipe_next = pipe_reg;
            if (clk_en_in) begin
                if (en_reg[gp] && !we_reg[gp]) begin
                    dout_next = mem[addr_reg[gp]];   // [RL8] [RL3]
                end else if (en_reg[gp] && we_reg[gp] && wthru_w[gp]) begin
                    dout_next = wdata_reg[gp];       // [RL4]
                end
                // normal write leaves the latch alone [RL3]
                pipe_next = dout_reg;                // [RL2]
            end
            // a sync clear needs an enabled edge; while frozen it waits
            if (!OUT_RST_ASYNC && lrst_w[gp] && clk_en_in) begin
                dout_next = DOUT_CLEAR;              // [RL5]
                pipe_next = DOUT_CLEAR;              // [RL5]
            end
        end

        if (OUT_RST_ASYNC) begin : g_async
            // async clear acts at once, even while the clock is frozen;
            // the cost is a reset net driven by fabric logic
            always_ff @(posedge clk_sys_in or negedge arst_n_in or posedge lrst_w[gp]) begin
                if (!arst_n_in) begin
                    dout_reg <= DOUT_CLEAR;
                    pipe_reg <= DOUT_CLEAR;
                end else if (lrst_w[gp]) begin
                    dout_reg <= DOUT_CLEAR;          // [RL5] [RL6] [RL7]
                    pipe_reg <= DOUT_CLEAR;          // [RL5] [RL6] [RL7]
                end else begin
                    dout_reg <= dout_next;
                    pipe_reg <= pipe_next;
                end
            end
        end else begin : g_sync
            always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    dout_reg <= DOUT_CLEAR;
                    pipe_reg <= DOUT_CLEAR;
                end else begin
                    dout_reg <= dout_next;
                    pipe_reg <= pipe_next;
                end
            end
        end

        // only the chosen flop reaches the pin; no mux sits behind it
        if (USE_PIPE) begin : g_piped
            assign rdata_w[gp] = pipe_reg; // [RL2]
        end else begin : g_direct
            assign rdata_w[gp] = dout_reg; // [RL2]
        end
    end

endmodule // dpbr_block_ram
`default_nettype wire

/* File: dpbr_user_port.sv */
// fabric-side model of one ram port: access and clear cycles
`timescale 1ns/1ns
`default_nettype none
module dpbr_user_port (
    // clock
    input  wire logic       clk_sys_in,
    // port controls
    output logic            en_out,
    output logic            we_out,
    output logic [3:0]      addr_out,
    output logic [7:0]      wdata_out,
    output logic            rst_out
);
    // idle from time zero
    initial {en_out, we_out, rst_out, addr_out, wdata_out} = '0;
    // held one edge; released lines flip so a stale word never looks valid
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        {en_out, we_out, addr_out, wdata_out} <= {1'h1, w, a, d};
        @(posedge clk_sys_in);
        {en_out, we_out, addr_out, wdata_out} <= {1'h0, 1'h0, ~a, ~d};
    endtask
    // one-edge output clear
    task automatic clr();
        @(posedge clk_sys_in);
        rst_out <= 1'h1;
        @(posedge clk_sys_in);
        rst_out <= 1'h0;
    endtask
endmodule // dpbr_user_port
`default_nettype wire

/* File: dpbr_chk_asserts.sv */
// port checker for the dual port block ram
`timescale 1ns/1ns
`default_nettype none
module dpbr_chk_asserts #(
    parameter int unsigned ADDR_W = dpbr_pkg::ADDR_W_DEF,
    parameter int unsigned DATA_W = dpbr_pkg::DATA_W_DEF
) (
    // clock, resets and freeze
    input wire logic              clk_sys_in,
    input wire logic              arst_n_in,
    input wire logic              clk_en_in,
    input wire logic              global_reset_low_in,
    // port a
    input wire logic              a_en_in,
    input wire logic              a_we_in,
    input wire logic [ADDR_W-1:0] a_addr_in,
    input wire logic [DATA_W-1:0] a_wdata_in,
    input wire logic              port_a_output_reset_in,
    input wire logic [DATA_W-1:0] a_rdata_out,
    // port b
    input wire logic              b_en_in,
    input wire logic              b_we_in,
    input wire logic [ADDR_W-1:0] b_addr_in,
    input wire logic [DATA_W-1:0] b_wdata_in,
    input wire logic              port_b_output_reset_in,
    input wire logic [DATA_W-1:0] b_rdata_out
);
    // enabled edge with no clear on that port
    wire logic a_ok = clk_en_in && global_reset_low_in && !port_a_output_reset_in;
    wire logic b_ok = clk_en_in && global_reset_low_in && !port_b_output_reset_in;
    default clocking dc @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    // sync clears land on the next enabled edge
    port_a_clear_a: assert property (clk_en_in && port_a_output_reset_in |=> a_rdata_out == '0)
        else $error("port a output not cleared");
    port_b_clear_a: assert property (clk_en_in && port_b_output_reset_in |=> b_rdata_out == '0)
        else $error("port b output not cleared");
    global_clear_a: assert property (clk_en_in && !global_reset_low_in |=> a_rdata_out == '0 && b_rdata_out == '0)
        else $error("global clear missed a port");
    port_isolation_a: assert property (
        (b_ok && !b_en_in)[*3] ##0 port_a_output_reset_in |=> $stable(b_rdata_out))
        else $error("port a clear disturbed port b");
    write_through_a: assert property (
        a_ok && a_en_in && a_we_in ##1 a_ok |=> a_rdata_out == $past(a_wdata_in, 2))
        else $error("write data not shown on port a");
    normal_hold_a: assert property (
        (b_ok && !b_en_in)[*2] ##1 (b_ok && b_en_in && b_we_in) ##1 b_ok[*2] |=> $stable(b_rdata_out))
        else $error("normal write changed port b output");
    a_latency_a: assert property (!$stable(a_rdata_out) && $past(clk_en_in, 2) |->
        $past(a_en_in, 2) || $past(port_a_output_reset_in || !global_reset_low_in))
        else $error("port a output changed without cause");
    b_latency_a: assert property (!$stable(b_rdata_out) && $past(clk_en_in, 2) && $past(clk_en_in, 3) |->
        $past(clk_en_in && b_en_in && !b_we_in, 3) || $past(port_b_output_reset_in || !global_reset_low_in))
        else $error("port b output changed without cause");
endmodule // dpbr_chk_asserts
`default_nettype wire

/* File: tb_top.sv */
// testbench top: two fabric port models drive the dual port ram
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // pins; port controls come from the fabric models
    logic            clk_sys_in = 1'h0;
    logic            arst_n_in = 1'h0;
    logic            clk_en_in = 1'h1;
    logic            global_reset_low_in = 1'h1;
    wire logic       a_en_in, a_we_in, port_a_output_reset_in, b_en_in, b_we_in, port_b_output_reset_in;
    wire logic [3:0] a_addr_in, b_addr_in;
    wire logic [7:0] a_wdata_in, b_wdata_in, a_rdata_out, b_rdata_out;
    int              errors = 0;
    int              cmp_count = 0;
    // port a writes through unregistered, port b is normal with output register
    dpbr_block_ram #(
        .ADDR_W    (4),
        .DATA_W    (8),
        .WR_MODE_A (dpbr_pkg::DPBR_WR_THROUGH),
        .OUT_REG_B (1'h1)
    ) i_dut (
        .clk_sys_in             (clk_sys_in),
        .arst_n_in              (arst_n_in),
        .clk_en_in              (clk_en_in),
        .global_reset_low_in    (global_reset_low_in),
        .a_en_in                (a_en_in),
        .a_we_in                (a_we_in),
        .a_addr_in              (a_addr_in),
        .a_wdata_in             (a_wdata_in),
        .port_a_output_reset_in (port_a_output_reset_in),
        .a_rdata_out            (a_rdata_out),
        .b_en_in                (b_en_in),
        .b_we_in                (b_we_in),
        .b_addr_in              (b_addr_in),
        .b_wdata_in             (b_wdata_in),
        .port_b_output_reset_in (port_b_output_reset_in),
        .b_rdata_out            (b_rdata_out)
    );
    dpbr_user_port i_ua (.clk_sys_in, .en_out(a_en_in), .we_out(a_we_in), .addr_out(a_addr_in),
                         .wdata_out(a_wdata_in), .rst_out(port_a_output_reset_in));
    dpbr_user_port i_ub (.clk_sys_in, .en_out(b_en_in), .we_out(b_we_in), .addr_out(b_addr_in),
                         .wdata_out(b_wdata_in), .rst_out(port_b_output_reset_in));
    // 25 MHz clock
    initial forever #20 clk_sys_in = ~clk_sys_in;
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // sample a port output n edges on, clear of the edge itself
    task automatic look(input int n, input bit port_b, input logic [7:0] exp);
        repeat (n) @(posedge clk_sys_in);
        #1;
        chk(port_b ? b_rdata_out : a_rdata_out, exp);
    endtask
    // writes and reads across ports, latencies per output register
    task automatic t_write_read();
        i_ua.acc(1'h1, 4'h3, 8'h5a);
        look(1, 1'h0, 8'h5a);
        i_ub.acc(1'h0, 4'h3, 8'h00);
        look(2, 1'h1, 8'h5a);
        i_ub.acc(1'h1, 4'h7, 8'hc3);
        look(2, 1'h1, 8'h5a);
        i_ub.acc(1'h0, 4'h7, 8'h00);
        look(1, 1'h1, 8'h5a);
        look(1, 1'h1, 8'hc3);
        i_ua.acc(1'h0, 4'h7, 8'h00);
        look(1, 1'h0, 8'hc3);
        $display("write and read test done");
    endtask
    // local clears hit one port only, global clear hits both
    task automatic t_clear();
        i_ua.clr();
        look(0, 1'h0, 8'h00);
        look(0, 1'h1, 8'hc3);
        i_ub.clr();
        look(0, 1'h1, 8'h00);
        i_ua.acc(1'h0, 4'h7, 8'h00);
        i_ub.acc(1'h0, 4'h3, 8'h00);
        look(2, 1'h1, 8'h5a);
        @(posedge clk_sys_in);
        global_reset_low_in <= 1'h0;
        @(posedge clk_sys_in);
        global_reset_low_in <= 1'h1;
        look(0, 1'h0, 8'h00);
        look(0, 1'h1, 8'h00);
        $display("clear test done");
    endtask
    // low enable freezes inputs, array and outputs; nothing is replayed later
    task automatic t_freeze();
        @(posedge clk_sys_in);
        clk_en_in <= 1'h0;
        i_ua.acc(1'h0, 4'h7, 8'h00);
        i_ub.acc(1'h1, 4'h3, 8'hff);
        look(2, 1'h0, 8'h00);
        @(posedge clk_sys_in);
        clk_en_in <= 1'h1;
        look(2, 1'h0, 8'h00);
        i_ub.acc(1'h0, 4'h3, 8'h00);
        look(2, 1'h1, 8'h5a);
        i_ua.acc(1'h0, 4'h7, 8'h00);
        look(1, 1'h0, 8'hc3);
        $display("freeze test done");
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // main sequence: 16 cycles of reset, then the scenarios
    initial begin
        repeat (16) @(posedge clk_sys_in);
        arst_n_in <= 1'h1;
        t_write_read();
        t_clear();
        t_freeze();
        conclude();
    end
    // hang guard counts as a mismatch
    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule // tb_top
bind dpbr_block_ram dpbr_chk_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (
    .clk_sys_in             (clk_sys_in),
    .arst_n_in              (arst_n_in),
    .clk_en_in              (clk_en_in),
    .global_reset_low_in    (global_reset_low_in),
    .a_en_in                (a_en_in),
    .a_we_in                (a_we_in),
    .a_addr_in              (a_addr_in),
    .a_wdata_in             (a_wdata_in),
    .port_a_output_reset_in (port_a_output_reset_in),
    .a_rdata_out            (a_rdata_out),
    .b_en_in                (b_en_in),
    .b_we_in                (b_we_in),
    .b_addr_in              (b_addr_in),
    .b_wdata_in             (b_wdata_in),
    .port_b_output_reset_in (port_b_output_reset_in),
    .b_rdata_out            (b_rdata_out)
);
`default_nettype wire
